//--- shared/cpx_pkg.sv
// Constants, types and the opcode timing table of the instruction execution core
package cpx_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [15:0] CTRL_OFF = 16'h0000;
  localparam logic [15:0] STATUS_OFF = 16'h0004;
  localparam logic [15:0] REGS_OFF = 16'h0008;
  localparam logic [15:0] PCPS_OFF = 16'h000c;
  localparam logic [3:0] MEM_PAGE = 4'h1;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CLR_ILL = 1;

  // ****************************************************************
  // Processor status bit positions and reset values
  // ****************************************************************
  localparam int PS_N = 7;
  localparam int PS_V = 6;
  localparam int PS_T = 5;
  localparam int PS_D = 3;
  localparam int PS_I = 2;
  localparam int PS_Z = 1;
  localparam int PS_C = 0;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] SP_RST = 8'hff;
  localparam logic [7:0] PS_RST = 8'h04;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] ZERO_PAGE = 8'h00;
  localparam logic [4:0] T_EXTRA = 5'h03;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_HALT = 2'b00, ST_RUN = 2'b01, ST_STOP = 2'b10, ST_WAIT = 2'b11
  } cpx_st_t;

  typedef enum logic [3:0] {
    M_IMP = 4'h0, M_IMM = 4'h1, M_A = 4'h2, M_ZP = 4'h3, M_ZPX = 4'h4, M_ZPY = 4'h5,
    M_ABS = 4'h6, M_ABSX = 4'h7, M_ABSY = 4'h8, M_BITA = 4'h9, M_BITZP = 4'ha
  } cpx_mode_t;

  typedef struct packed {
    cpx_mode_t mode;
    logic [1:0] len;
    logic [4:0] cyc;
  } cpx_dec_t;

  typedef struct packed {
    cpx_st_t st;
    logic run;
    logic illegal;
    logic osc_run;
    logic [4:0] cnt;
    logic [7:0] op;
    logic [15:0] pc;
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] s;
    logic [7:0] ps;
    logic [15:0] wake_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic wake_s1;
    logic wake_s2;
  } cpx_state_t;

  localparam cpx_state_t STATE_RST = '{st: ST_HALT, run: 1'b0, illegal: 1'b0,
    osc_run: 1'b1, cnt: 5'h00, op: 8'hea, pc: PC_RST, a: 8'h00, x: 8'h00, y: 8'h00,
    s: SP_RST, ps: PS_RST, wake_cnt: 16'h0000, pready: 1'b0, pslverr: 1'b0,
    prdata: 32'h0000_0000, wake_s1: 1'b0, wake_s2: 1'b0};

  // Opcodes whose count grows when the memory-mode flag is set
  function automatic logic cpx_note1(input logic [7:0] op);
    return ((op[7:5] == 3'b000) || (op[7:5] == 3'b111)) && (op[1:0] == 2'b01);
  endfunction : cpx_note1

  // Addressing mode, byte length and cycle count; length zero marks an unknown code
  function automatic cpx_dec_t cpx_decode(input logic [7:0] op);
    case (op)
      8'h4a, 8'h2a, 8'h6a: return '{M_A, 2'd1, 5'd2};
      8'h46, 8'h26, 8'h66: return '{M_ZP, 2'd2, 5'd5};
      8'h56, 8'h36, 8'h76: return '{M_ZPX, 2'd2, 5'd6};
      8'h4e, 8'h2e, 8'h6e: return '{M_ABS, 2'd3, 5'd6};
      8'h5e, 8'h3e, 8'h7e: return '{M_ABSX, 2'd3, 5'd7};
      8'h62: return '{M_ZPX, 2'd2, 5'd15};
      8'hea, 8'h38, 8'hf8, 8'h78, 8'h32, 8'h42, 8'hc2,
      8'haa, 8'ha8, 8'hba, 8'h8a, 8'h9a, 8'h98: return '{M_IMP, 2'd1, 5'd2};
      8'h48, 8'h08: return '{M_IMP, 2'd1, 5'd3};
      8'h68, 8'h28: return '{M_IMP, 2'd1, 5'd4};
      8'h40, 8'h60: return '{M_IMP, 2'd1, 5'd6};
      8'h09, 8'he9: return '{M_IMM, 2'd2, 5'd2};
      8'h05, 8'he5, 8'h64: return '{M_ZP, 2'd2, 5'd3};
      8'h15, 8'hf5: return '{M_ZPX, 2'd2, 5'd4};
      8'h0d, 8'hed: return '{M_ABS, 2'd3, 5'd4};
      8'h1d, 8'hfd: return '{M_ABSX, 2'd3, 5'd5};
      8'h19, 8'hf9: return '{M_ABSY, 2'd3, 5'd5};
      8'h82: return '{M_ZP, 2'd2, 5'd8};
      8'h85, 8'h86, 8'h84: return '{M_ZP, 2'd2, 5'd4};
      8'h95, 8'h94: return '{M_ZPX, 2'd2, 5'd5};
      8'h96: return '{M_ZPY, 2'd2, 5'd5};
      8'h8d, 8'h8e, 8'h8c: return '{M_ABS, 2'd3, 5'd5};
      8'h9d: return '{M_ABSX, 2'd3, 5'd6};
      8'h99: return '{M_ABSY, 2'd3, 5'd6};
      default: begin
        if (op[4] == 1'b0 && op[3:0] == 4'hb) begin
          return '{M_BITA, 2'd1, 5'd2};
        end else if (op[4] == 1'b0 && op[3:0] == 4'hf) begin
          return '{M_BITZP, 2'd2, 5'd5};
        end
        return '{M_IMP, 2'd0, 5'd2};
      end
    endcase
  endfunction : cpx_decode

endpackage : cpx_pkg

//--- hw/cpx_core.sv
// Instruction execution core for a subset of an 8-bit CPU, with APB control
// Operation
// - Logical right shift: zero into bit 7, old bit 0 to carry, N cleared.
// - Multiply A by zero-page X byte; high byte pushed, low byte into A.
// - No-operation only steps the program counter; two cycles, no flags.
// - OR into A, or into byte at X in memory mode; N and Z updated.
// - OR and subtract-borrow take three extra cycles in memory mode.
// - Push A or status at stack pointer, then decrement pointer; three cycles.
// - Pull A: increment pointer, load A, update N and Z; four cycles.
// - Pull status: increment pointer, load whole status byte; four cycles.
// - Return from interrupt pops status, PC low, PC high; six cycles.
// - Return from subroutine pops PC low, high, then adds one.
// - Rotates go through carry both ways and update N and Z.
// - Nibble rotate swaps halves of a zero-page byte; eight cycles, no flags.
// - Subtract with borrow on A or byte at X; sets N, V, Z, C.
// - In decimal mode the N, V, Z results of subtraction need not be right.
// - Bit set forces bit i of A or a zero-page byte to one.
// - Flag set opcodes set carry, decimal, irq disable or memory mode only.
// - Store A writes memory, keeps registers and flags; four to six cycles.
// - Stop clears oscillator control; only reset or interrupt wakes the core.
// - Store X or Y writes memory, keeps registers and flags.
// - Transfers copy and set N and Z, except into stack pointer.
// - Test reads a zero-page byte and sets N and Z, no write.
// - Wait halts execution with state kept until the wake timer counts down to zero.
// - A status flag selects memory mode with X addressing the destination.
// - The memory-mode destination is the byte addressed by X itself.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module cpx_core #(
  parameter int AW = 10,
  parameter logic [15:0] WAKE_CYCLES = 16'h0100
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake_irq,
  output logic osc_run,
  output logic core_wait
);
  import cpx_pkg::*;

  cpx_state_t r;
  cpx_state_t n;
  logic [7:0] mem [0:(1<<AW)-1];
  logic mem_we;
  logic [15:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] fetch;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] m;
  logic [7:0] dx;
  logic [7:0] dest;
  logic [7:0] opnd;
  logic [7:0] sh;
  logic [7:0] res;
  logic [7:0] mask;
  logic [8:0] diff;
  logic [4:0] lo;
  logic [15:0] prod;
  logic [15:0] ea;
  logic [15:0] sp0;
  logic [15:0] sp1;
  logic [15:0] sp2;
  logic [15:0] sp3;
  logic [15:0] mem_idx;
  logic cout;
  logic nz_upd;
  logic tmode;
  logic apb_wr;
  logic is_mem;
  logic exec;
  logic first;
  cpx_dec_t d;
  cpx_dec_t fd;

  // ****************************************************************
  // Sequencing helpers
  // ****************************************************************
  assign exec = (r.st == ST_RUN) && (r.cnt == 5'd1);
  assign first = (r.st == ST_RUN) && (r.cnt == 5'd0) && r.run;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = r;
    mem_we = 1'b0;
    mem_wa = 16'h0000;
    mem_wd = 8'h00;
    nz_upd = 1'b0;
    res = 8'h00;
    cout = 1'b0;
    mask = 8'h00;
    sh = 8'h00;
    fetch = mem[r.pc[AW-1:0]];
    fd = cpx_decode(fetch);
    d = cpx_decode(r.op);
    b1 = mem[AW'(r.pc + 16'd1)];
    b2 = mem[AW'(r.pc + 16'd2)];
    tmode = r.ps[PS_T];
    // Effective address per addressing mode
    case (d.mode)
      M_ZP, M_BITZP: ea = {ZERO_PAGE, b1};
      M_ZPX: ea = {ZERO_PAGE, 8'(b1 + r.x)};
      M_ZPY: ea = {ZERO_PAGE, 8'(b1 + r.y)};
      M_ABS: ea = {b2, b1};
      M_ABSX: ea = 16'({b2, b1} + {8'h00, r.x});
      M_ABSY: ea = 16'({b2, b1} + {8'h00, r.y});
      default: ea = 16'h0000;
    endcase
    m = mem[ea[AW-1:0]];
    dx = mem[AW'({ZERO_PAGE, r.x})];
    sp0 = {STACK_PAGE, r.s};
    sp1 = {STACK_PAGE, 8'(r.s + 8'd1)};
    sp2 = {STACK_PAGE, 8'(r.s + 8'd2)};
    sp3 = {STACK_PAGE, 8'(r.s + 8'd3)};
    dest = tmode ? dx : r.a;
    opnd = (d.mode == M_IMM) ? b1 : m;
    diff = {1'b0, dest} - {1'b0, opnd} - {8'h00, ~r.ps[PS_C]};
    lo = {1'b0, dest[3:0]} - {1'b0, opnd[3:0]} - {4'h0, ~r.ps[PS_C]};
    prod = {8'h00, r.a} * {8'h00, m};
    n.wake_s1 = wake_irq;
    n.wake_s2 = r.wake_s1;

    // Core sequencer: cycle 0 latches the opcode, the last cycle commits
    unique case (r.st)
      ST_HALT: begin
      end
      ST_RUN: begin
        if (r.cnt == 5'd0) begin
          if (!r.run) begin
            n.st = ST_HALT;
          end else if (fd.len == 2'd0) begin
            n.illegal = 1'b1;
            n.run = 1'b0;
            n.st = ST_HALT;
          end else begin
            n.op = fetch;
            n.cnt = fd.cyc - 5'd1 + ((cpx_note1(fetch) && tmode) ? T_EXTRA : 5'd0);
          end
        end else begin
          n.cnt = r.cnt - 5'd1;
        end
        if (exec) begin
          n.pc = r.pc + {14'h0000, d.len};
          case (r.op)
            // Shifts and rotates on A or memory
            8'h4a, 8'h46, 8'h56, 8'h4e, 8'h5e, 8'h2a, 8'h26, 8'h36, 8'h2e, 8'h3e,
            8'h6a, 8'h66, 8'h76, 8'h6e, 8'h7e: begin
              sh = (d.mode == M_A) ? r.a : m;
              case (r.op[7:5])
                3'b010: begin
                  res = {1'b0, sh[7:1]};
                  cout = sh[0];
                end
                3'b001: begin
                  res = {sh[6:0], r.ps[PS_C]};
                  cout = sh[7];
                end
                default: begin
                  res = {r.ps[PS_C], sh[7:1]};
                  cout = sh[0];
                end
              endcase
              n.ps[PS_C] = cout;
              nz_upd = 1'b1;
              if (d.mode == M_A) begin
                n.a = res;
              end else begin
                mem_we = 1'b1;
                mem_wa = ea;
                mem_wd = res;
              end
            end
            8'h62: begin
              mem_we = 1'b1;
              mem_wa = sp0;
              mem_wd = prod[15:8];
              n.s = r.s - 8'd1;
              n.a = prod[7:0];
            end
            8'h09, 8'h05, 8'h15, 8'h0d, 8'h1d, 8'h19: begin
              res = dest | opnd;
              nz_upd = 1'b1;
              if (tmode) begin
                mem_we = 1'b1;
                mem_wa = {ZERO_PAGE, r.x};
                mem_wd = res;
              end else begin
                n.a = res;
              end
            end
            8'he9, 8'he5, 8'hf5, 8'hed, 8'hfd, 8'hf9: begin
              res = diff[7:0];
              // Decimal correction; N, V and Z follow the binary difference
              if (r.ps[PS_D] && lo[4]) begin
                res = res - 8'h06;
              end
              if (r.ps[PS_D] && diff[8]) begin
                res = res - 8'h60;
              end
              n.ps[PS_C] = ~diff[8];
              n.ps[PS_V] = (dest[7] ^ opnd[7]) & (dest[7] ^ diff[7]);
              n.ps[PS_N] = diff[7];
              n.ps[PS_Z] = (diff[7:0] == 8'h00);
              if (tmode) begin
                mem_we = 1'b1;
                mem_wa = {ZERO_PAGE, r.x};
                mem_wd = res;
              end else begin
                n.a = res;
              end
            end
            8'h48, 8'h08: begin
              mem_we = 1'b1;
              mem_wa = sp0;
              mem_wd = r.op[6] ? r.a : r.ps;
              n.s = r.s - 8'd1;
            end
            8'h68: begin
              n.s = r.s + 8'd1;
              n.a = mem[sp1[AW-1:0]];
              res = mem[sp1[AW-1:0]];
              nz_upd = 1'b1;
            end
            8'h28: begin
              n.s = r.s + 8'd1;
              n.ps = mem[sp1[AW-1:0]];
            end
            8'h40: begin
              n.s = r.s + 8'd3;
              n.ps = mem[sp1[AW-1:0]];
              n.pc = {mem[sp3[AW-1:0]], mem[sp2[AW-1:0]]};
            end
            8'h60: begin
              n.s = r.s + 8'd2;
              n.pc = 16'({mem[sp2[AW-1:0]], mem[sp1[AW-1:0]]} + 16'd1);
            end
            8'h82: begin
              mem_we = 1'b1;
              mem_wa = ea;
              mem_wd = {m[3:0], m[7:4]};
            end
            8'h64: begin
              res = m;
              nz_upd = 1'b1;
            end
            8'h38: n.ps[PS_C] = 1'b1;
            8'hf8: n.ps[PS_D] = 1'b1;
            8'h78: n.ps[PS_I] = 1'b1;
            8'h32: n.ps[PS_T] = 1'b1;
            8'h85, 8'h95, 8'h8d, 8'h9d, 8'h99, 8'h86, 8'h96, 8'h8e, 8'h84, 8'h94, 8'h8c: begin
              mem_we = 1'b1;
              mem_wa = ea;
              mem_wd = (r.op[1:0] == 2'b01) ? r.a : (r.op[1] ? r.x : r.y);
            end
            8'haa, 8'hba: begin
              res = r.op[4] ? r.s : r.a;
              n.x = res;
              nz_upd = 1'b1;
            end
            8'ha8: begin
              n.y = r.a;
              res = r.a;
              nz_upd = 1'b1;
            end
            8'h8a, 8'h98: begin
              res = r.op[4] ? r.y : r.x;
              n.a = res;
              nz_upd = 1'b1;
            end
            8'h9a: n.s = r.x;
            8'h42: begin
              n.osc_run = 1'b0;
              n.st = ST_STOP;
            end
            8'hc2: begin
              n.wake_cnt = WAKE_CYCLES;
              n.st = ST_WAIT;
            end
            8'hea: begin
            end
            default: begin
              mask = 8'h01 << r.op[7:5];
              if (d.mode == M_BITA) begin
                n.a = r.a | mask;
              end else begin
                mem_we = 1'b1;
                mem_wa = ea;
                mem_wd = m | mask;
              end
            end
          endcase
          if (nz_upd) begin
            n.ps[PS_N] = res[7];
            n.ps[PS_Z] = (res == 8'h00);
          end
        end
      end
      ST_STOP: begin
        if (r.wake_s2) begin
          n.osc_run = 1'b1;
          n.st = ST_RUN;
          n.cnt = 5'd0;
        end
      end
      ST_WAIT: begin
        if (r.wake_cnt == 16'h0000) begin
          n.st = ST_RUN;
          n.cnt = 5'd0;
        end else begin
          n.wake_cnt = r.wake_cnt - 16'd1;
        end
      end
    endcase

    // APB slave: answer in the second access cycle
    is_mem = (paddr[15:12] == MEM_PAGE);
    mem_idx = 16'(paddr[AW+1:2]);
    apb_wr = psel && penable && r.pready && pwrite && !r.pslverr;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (psel && penable && !r.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      if (is_mem) begin
        n.pslverr = (r.st != ST_HALT);
        n.prdata = {24'h000000, mem[mem_idx[AW-1:0]]};
      end else if (paddr == CTRL_OFF) begin
        n.prdata = {30'h00000000, 1'b0, r.run};
      end else if (paddr == STATUS_OFF && !pwrite) begin
        n.prdata = {16'h0000, r.op, 2'b00, r.osc_run, r.illegal, r.run, 1'b0, r.st};
      end else if (paddr == REGS_OFF || paddr == PCPS_OFF) begin
        n.pslverr = pwrite && (r.st != ST_HALT);
        n.prdata = (paddr == REGS_OFF) ? {r.s, r.y, r.x, r.a} : {8'h00, r.ps, r.pc};
      end else begin
        n.pslverr = 1'b1;
      end
    end
    // Register writes take effect at the completing edge
    if (apb_wr) begin
      if (is_mem) begin
        mem_we = 1'b1;
        mem_wa = mem_idx;
        mem_wd = pwdata[7:0];
      end else if (paddr == CTRL_OFF) begin
        n.run = pwdata[CTRL_RUN];
        // A clear never hides an illegal opcode caught in the same cycle
        if (pwdata[CTRL_CLR_ILL] && !(first && fd.len == 2'd0)) begin
          n.illegal = 1'b0;
        end
        if (pwdata[CTRL_RUN] && r.st == ST_HALT) begin
          n.st = ST_RUN;
          n.cnt = 5'd0;
        end
      end else if (paddr == REGS_OFF) begin
        {n.s, n.y, n.x, n.a} = pwdata;
      end else if (paddr == PCPS_OFF) begin
        n.pc = pwdata[15:0];
        n.ps = pwdata[23:16];
      end
    end
  end

  // ****************************************************************
  // Registers and memory
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= STATE_RST;
    end else begin
      r <= n;
    end
  end

  // Byte memory, one write port shared by core and bus
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_wa[AW-1:0]] <= mem_wd;
    end
  end

  // Outputs straight from state flip-flops; core_wait decoded from the state
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign osc_run = r.osc_run;
  assign core_wait = (r.st == ST_WAIT);

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_lsr_clears_n: assert property (@(posedge pclk) disable iff (!presetn)
    exec && r.op == 8'h4a |=> !r.ps[PS_N] && r.ps[PS_C] == $past(r.a[0])
      && r.a == {1'b0, $past(r.a[7:1])})
    else $error("shift right result or flags wrong");
  a_mul_timing: assert property (@(posedge pclk) disable iff (!presetn)
    first && fetch == 8'h62 |-> ##1 (r.cnt != 5'd0) [*8] ##7 (r.st == ST_RUN && r.cnt == 5'd0))
    else $error("multiply did not take fifteen cycles");
  a_nop_pc_step: assert property (@(posedge pclk) disable iff (!presetn)
    exec && r.op == 8'hea |=> r.pc == $past(r.pc) + 16'd1 && r.ps == $past(r.ps))
    else $error("no-operation changed more than the pc");
  a_or_mem_cycles: assert property (@(posedge pclk) disable iff (!presetn)
    first && fetch == 8'h05 && r.ps[PS_T] |-> ##6 (r.st == ST_RUN && r.cnt == 5'd0))
    else $error("memory-mode OR did not take six cycles");
  a_push_sp_down: assert property (@(posedge pclk) disable iff (!presetn)
    exec && (r.op == 8'h48 || r.op == 8'h08) |=> r.s == $past(r.s) - 8'd1)
    else $error("push did not decrement the stack pointer");
  a_pull_sp_up: assert property (@(posedge pclk) disable iff (!presetn)
    exec && r.op == 8'h68 |=> r.s == $past(r.s) + 8'd1 && r.ps[PS_Z] == (r.a == 8'h00))
    else $error("pull accumulator stack or flags wrong");
  a_rti_three_pops: assert property (@(posedge pclk) disable iff (!presetn)
    exec && r.op == 8'h40 |=> r.s == $past(r.s) + 8'd3)
    else $error("return from interrupt popped wrong count");
  a_rrf_keeps_flags: assert property (@(posedge pclk) disable iff (!presetn)
    exec && r.op == 8'h82 |=> $stable(r.ps) && $stable(r.a))
    else $error("nibble rotate touched flags");
  a_txs_no_flags: assert property (@(posedge pclk) disable iff (!presetn)
    exec && r.op == 8'h9a |=> r.ps == $past(r.ps) && r.s == $past(r.x))
    else $error("transfer into stack pointer changed flags");
  a_stop_osc_off: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ST_STOP |-> !r.osc_run ##1 (r.st == ST_STOP || r.osc_run))
    else $error("oscillator control not cleared while stopped");

endmodule : cpx_core

//--- verification/cpx_apb_host.sv
// APB master model that speaks to the core's register bus
`timescale 1ns/100ps
module cpx_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ****************************************************************
  // Bus transfer
  // ****************************************************************
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
  end
  // Setup, then access held until pready; data line inverted once released
  task xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge pclk);
  endtask : xfer
endmodule : cpx_apb_host

//--- verification/cpx_core_tb_top.sv
// Self-checking bench for the instruction execution core
`timescale 1ns/100ps
module cpx_core_tb_top;
  import cpx_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic wake_irq = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, osc_run, core_wait, e;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  int wait_len = 0;
  // ****************************************************************
  // Clock, design and bus model
  // ****************************************************************
  always #5 pclk = ~pclk;
  cpx_core #(.WAKE_CYCLES(16'h0004)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_irq(wake_irq), .osc_run(osc_run),
    .core_wait(core_wait));
  cpx_apb_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Timeout and length of the wait state
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (core_wait === 1'b1) wait_len <= wait_len + 1;
    if (cycles == 20000) begin
      fails++;
      final_report;
    end
  end
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task wr(input logic [15:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q, e);
  endtask : wr
  task rd(input logic [15:0] a, input logic [31:0] exp);
    host_u.xfer(1'b0, a, 32'h0000_0000, q, e);
    cmp(q, exp);
  endtask : rd
  // Write n bytes into memory, or with chk set compare them
  task mem(input logic chk, input int at, input int n, input logic [255:0] b);
    for (int i = 0; i < n; i++) begin
      if (chk) rd(16'h1000 + 16'(4 * (at + i)), {24'h000000, b[8 * (n - 1 - i) +: 8]});
      else wr(16'h1000 + 16'(4 * (at + i)), {24'h000000, b[8 * (n - 1 - i) +: 8]});
    end
  endtask : mem
  // Load registers, pc 0200, start, then, unless stay is set, poll until halted
  task run(input logic [31:0] regs, input logic [7:0] ps, input logic stay);
    int k;
    wr(REGS_OFF, regs);
    wr(PCPS_OFF, {8'h00, ps, 16'h0200});
    wr(CTRL_OFF, 32'h0000_0001);
    k = 0;
    q = 32'h0000_0001;
    while (!stay && q[1:0] !== 2'b00 && k < 300) begin
      host_u.xfer(1'b0, STATUS_OFF, 32'h0000_0000, q, e);
      k++;
    end
  endtask : run
  task osc_is(input logic v);
    int k;
    for (k = 0; k < 100 && osc_run !== v; k++) @(posedge pclk);
    cmp({31'h0, osc_run}, {31'h0, v});
  endtask : osc_is
  task final_report;
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(REGS_OFF, 32'hff00_0000);
    host_u.xfer(1'b0, 16'h0010, 32'h0000_0000, q, e);
    cmp({31'h0, e}, 32'h0000_0001);
    // Shifts, rotates, stores, pushes, OR and subtract, transfers, bit and flag set
    mem(1'b0, 16'h200, 29, 232'h4a85202a85216a85224808090fe90f852586238424aa98ba0b38f87802);
    run(32'hff22_1081, 8'h00, 1'b0);
    rd(REGS_OFF, 32'hfd22_fd23);
    host_u.xfer(1'b0, PCPS_OFF, 32'h0000_0000, q, e);
    cmp({24'h0, q[23:16]}, 32'h0000_008d);
    mem(1'b1, 16'h20, 6, 48'h408140102240);
    mem(1'b1, 16'h1fe, 2, 16'h0140);
    // Memory mode OR and subtract, multiply, nibble rotate, test, pulls, returns
    mem(1'b0, 16'h30, 3, 24'h0ff050);
    mem(1'b0, 16'h40, 2, 16'ha500);
    mem(1'b0, 16'h100, 6, 48'h00c30003ff03);
    mem(1'b0, 16'h300, 1, 8'h60);
    mem(1'b0, 16'h400, 1, 8'h02);
    mem(1'b0, 16'h200, 14, 112'h320531e531620282406441682840);
    run(32'hff00_3006, 8'h01, 1'b0);
    rd(REGS_OFF, 32'h0500_3001);
    host_u.xfer(1'b0, PCPS_OFF, 32'h0000_0000, q, e);
    cmp({24'h0, q[23:16]}, 32'h0000_00c3);
    mem(1'b1, 16'h30, 1, 8'h0f);
    mem(1'b1, 16'h40, 2, 16'h5a00);
    mem(1'b1, 16'h1ff, 1, 8'h01);
    // No-operation, wait, then stop woken by the interrupt pin
    mem(1'b0, 16'h200, 5, 40'hea9ac24202);
    run(32'h1234_5678, 8'h00, 1'b1);
    osc_is(1'b0);
    cmp(32'(wait_len), 32'h0000_0005);
    host_u.xfer(1'b1, 16'h1000, 32'h0000_0000, q, e);
    cmp({31'h0, e}, 32'h0000_0001);
    wake_irq <= 1'b1;
    osc_is(1'b1);
    wake_irq <= 1'b0;
    run(32'h1234_5678, 8'h00, 1'b0);
    rd(REGS_OFF, 32'h5634_5678);
    final_report;
  end
endmodule : cpx_core_tb_top
